// *** autotune_pkg.sv ***
// Shared constants and carrier types for the motor autotune sequencer.
// Assumes a single 250 MHz system clock; measurement and gain arithmetic engines live outside.
package autotune_pkg;
   // ****************************************
   // Autotune selector codes
   // ****************************************
   localparam logic [2:0] AT_NONE = 3'h0;
   localparam logic [2:0] AT_STAT = 3'h1;
   localparam logic [2:0] AT_ROT = 3'h2;
   localparam logic [2:0] AT_INERTIA = 3'h3;
   localparam logic [2:0] AT_CALC = 3'h4;
   // ****************************************
   // Timing
   // ****************************************
   localparam longint CLK_HZ = 250_000_000;
   localparam longint ROT_TIME_S = 30;
   localparam longint ATTEMPT_TIME_MS = 2000;
   localparam longint OPT_TICK_TIME_MS = 1;
   // ****************************************
   // Fractions of rated values
   // ****************************************
   localparam int ROT_FREQ_NUM = 2;
   localparam int ROT_FREQ_DEN = 3;
   localparam int INERTIA_SPEED_NUM = 3;
   localparam int INERTIA_SPEED_SHIFT = 2;
   localparam logic [2:0] TORQUE_SHIFT_FIRST = 3'h4;
   localparam logic [2:0] TORQUE_SHIFT_LAST = 3'h0;
   localparam int OPT_SPEED_SHIFT = 3;
   localparam int OPT_LOAD_ON_NUM = 5;
   localparam int OPT_LOAD_ON_SHIFT = 3;
   localparam int OPT_LOAD_OFF_SHIFT = 1;
   localparam int OPT_FAST_SHIFT = 4;
   localparam int PID_SHIFT = 8;
   // ****************************************
   // Mode codes
   // ****************************************
   localparam logic [1:0] OPT_OFF = 2'h0;
   localparam logic [1:0] OPT_NORMAL = 2'h1;
   localparam logic [1:0] OPT_FAST = 2'h2;
   localparam logic GAINSET_ONE = 1'b0;
   localparam logic [1:0] TUNE_USER = 2'h0;
   localparam logic [1:0] TUNE_BANDWIDTH = 2'h1;
   localparam logic [1:0] TUNE_COMPLIANCE = 2'h2;
   // ****************************************
   // Carrier types
   // ****************************************
   typedef struct packed {
      logic [15:0] kp;
      logic [15:0] ki;
      logic [15:0] kd;
   } speed_gains_t;
   typedef struct packed {
      logic [15:0] kp;
      logic [15:0] ki;
   } loop_gains_t;
   typedef struct packed {
      logic [15:0] resistance;
      logic [15:0] inductance;
   } stat_meas_t;
   typedef struct packed {
      logic [15:0] inductance;
      logic [15:0] bp_one;
      logic [15:0] bp_two;
   } rot_meas_t;
endpackage

// *** speed_pid.sv ***
// Speed controller: P and I on speed error, D on the feedback only.
// Assumes gains are stable between ticks; runs every cycle while enabled.
`timescale 1ns/1ps
`default_nettype none
module speed_pid
   import autotune_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic enable,
   input wire speed_gains_t gains,
   input wire logic signed [16:0] speed_ref,
   input wire logic signed [16:0] speed_fb,
   output logic signed [31:0] torque_demand
);
   logic signed [31:0] integ;
   logic signed [16:0] fb_prev;
   wire logic signed [17:0] err = 18'(speed_ref) - 18'(speed_fb);
   wire logic signed [17:0] dfb = 18'(speed_fb) - 18'(fb_prev);
   wire logic signed [31:0] p_term = 32'(err * $signed({1'b0, gains.kp}));
   wire logic signed [31:0] i_step = 32'(err * $signed({1'b0, gains.ki}));
   wire logic signed [31:0] d_term = 32'(dfb * $signed({1'b0, gains.kd}));
   wire logic signed [31:0] sum = p_term + integ - d_term;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         integ <= 32'sh0000_0000;
         fb_prev <= 17'sh0_0000;
         torque_demand <= 32'sh0000_0000;
      end else if (!enable) begin
         integ <= 32'sh0000_0000;
         fb_prev <= speed_fb;
         torque_demand <= 32'sh0000_0000;
      end else begin
         integ <= integ + (i_step >>> PID_SHIFT);
         fb_prev <= speed_fb;
         torque_demand <= sum >>> PID_SHIFT;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   a_pid_idle_zero: assert property (!enable |=> torque_demand == 32'sh0000_0000)
      else $error("speed controller output not cleared while disabled");
endmodule
`default_nettype wire

// *** slip_optimizer.sv ***
// Online rated-speed optimizer with load hysteresis.
// Assumes slip_error comes from the motor model and opt_tick from a divider.
`timescale 1ns/1ps
`default_nettype none
module slip_optimizer
   import autotune_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic opt_tick,
   input wire logic [1:0] mode,
   input wire logic feedback_present,
   input wire logic [15:0] speed,
   input wire logic [15:0] load,
   input wire logic [15:0] rated_load,
   input wire logic [15:0] saved_speed,
   input wire logic signed [15:0] slip_error,
   output logic [15:0] motor_rated_speed,
   output logic opt_active
);
   logic loaded;
   wire logic mode_on = (mode == OPT_NORMAL) || (mode == OPT_FAST);
   wire logic speed_ok = speed > (motor_rated_speed >> OPT_SPEED_SHIFT);
   wire logic [15:0] load_on = 16'((20'(rated_load) * OPT_LOAD_ON_NUM) >> OPT_LOAD_ON_SHIFT);
   wire logic load_high = load > load_on;
   wire logic load_low = load < (rated_load >> OPT_LOAD_OFF_SHIFT);
   wire logic allowed = mode_on && feedback_present && speed_ok;
   wire logic next_active = allowed && (load_high || (opt_active && !load_low));
   wire logic signed [15:0] step = (mode == OPT_FAST) ? slip_error :
      (slip_error >>> OPT_FAST_SHIFT);
   wire logic [15:0] next_speed = motor_rated_speed + 16'(step);
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         loaded <= 1'b0;
         opt_active <= 1'b0;
         motor_rated_speed <= 16'h0000;
      end else begin
         loaded <= 1'b1;
         opt_active <= next_active;
         if (!loaded)
            motor_rated_speed <= saved_speed;
         else if (opt_active && opt_tick)
            motor_rated_speed <= next_speed;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   a_opt_needs_fb: assert property (!feedback_present |=> !opt_active)
      else $error("optimizer active without external feedback");
   a_opt_load_drop: assert property (opt_active && load_low |=> !opt_active)
      else $error("optimizer stayed on below half rated load");
   a_opt_restore: assert property ($rose(loaded) |-> motor_rated_speed == $past(saved_speed))
      else $error("rated speed not restored from saved value");
endmodule
`default_nettype wire

// *** motor_autotune_sequencer.sv ***
// Autotune sequencing, current-loop gain capture and speed gain selection.
// Assumes measurement and gain arithmetic engines outside; pins are async.
`timescale 1ns/1ps
`default_nettype none
module motor_autotune_sequencer
   import autotune_pkg::*;
#(
   parameter longint ROT_CYCLES = ROT_TIME_S * CLK_HZ,
   parameter longint ATTEMPT_CYCLES = ATTEMPT_TIME_MS * CLK_HZ / 1000,
   parameter longint OPT_TICK_CYCLES = OPT_TICK_TIME_MS * CLK_HZ / 1000
)
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic enable_pin,
   input wire logic run_pin,
   input wire logic [2:0] autotune_select,
   input wire logic drive_enable_param,
   input wire logic control_word_disable,
   input wire logic direction_reverse,
   input wire logic [15:0] motor_rated_frequency,
   input wire logic [15:0] rated_speed_saved,
   input wire logic [15:0] rated_torque,
   input wire logic [15:0] rated_load,
   input wire logic [15:0] speed_fb,
   input wire logic [15:0] load_fb,
   input wire logic feedback_present,
   input wire logic signed [15:0] slip_error,
   input wire logic stat_meas_done,
   input wire stat_meas_t stat_meas,
   input wire rot_meas_t rot_meas,
   input wire loop_gains_t current_gain_calc,
   input wire logic [1:0] rated_speed_optimizer_mode,
   input wire logic speed_gain_set_select,
   input wire logic [1:0] speed_gain_tuning_method,
   input wire speed_gains_t user_gain_set_one,
   input wire speed_gains_t user_gain_set_two,
   input wire loop_gains_t bandwidth_gain_calc,
   input wire loop_gains_t compliance_gain_calc,
   input wire logic signed [16:0] speed_ref,
   output logic run_permit,
   output logic inhibit,
   output logic test_busy,
   output logic stationary_active,
   output logic test_reverse,
   output logic [15:0] freq_ref,
   output logic [15:0] torque_limit,
   output logic [15:0] stator_resistance,
   output logic [15:0] transient_inductance,
   output logic [15:0] stator_inductance,
   output logic [15:0] saturation_breakpoint_one,
   output logic [15:0] saturation_breakpoint_two,
   output logic [15:0] current_loop_prop_gain,
   output logic [15:0] current_loop_int_gain,
   output logic [31:0] motor_load_inertia,
   output logic inertia_tune_fail_trip,
   output logic [15:0] motor_rated_speed,
   output logic optimizer_active,
   output speed_gains_t active_speed_gains,
   output logic signed [31:0] torque_demand
);
   // ****************************************
   // Pin synchronisers and start detection
   // ****************************************
   typedef enum logic [6:0] {
      ST_IDLE = 7'b000_0001,
      ST_STAT = 7'b000_0010,
      ST_CALC = 7'b000_0100,
      ST_ROT = 7'b000_1000,
      ST_ACC = 7'b001_0000,
      ST_DEC = 7'b010_0000,
      ST_INHIBIT = 7'b100_0000
   } seq_state_t;

   function automatic logic is_test_code(input logic [2:0] code);
      is_test_code = (code >= AT_STAT) && (code <= AT_CALC);
   endfunction

   logic [1:0] pin_meta;
   logic [1:0] pin_sync;
   logic go_q;
   seq_state_t state;
   seq_state_t next_state;
   logic [2:0] code;
   logic [2:0] torque_shift;
   logic [39:0] rot_cnt;
   logic [31:0] acc_cnt;
   logic [31:0] dec_cnt;
   logic [31:0] tick_cnt;
   logic opt_tick;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pin_meta <= 2'h0;
         pin_sync <= 2'h0;
      end else begin
         pin_meta <= {run_pin, enable_pin};
         pin_sync <= pin_meta;
      end
   end

   wire logic enable_s = pin_sync[0];
   wire logic run_s = pin_sync[1];
   wire logic go = enable_s && run_s;
   wire logic go_rise = go && !go_q;
   wire logic start_test = go_rise && is_test_code(autotune_select);
   wire logic controlled_disable = !enable_s || !drive_enable_param ||
      control_word_disable;

   // ****************************************
   // Derived targets
   // ****************************************
   wire logic [15:0] rot_freq = 16'((32'(motor_rated_frequency) * ROT_FREQ_NUM) / ROT_FREQ_DEN);
   wire logic [15:0] inertia_target =
      16'((32'(motor_rated_speed) * INERTIA_SPEED_NUM) >> INERTIA_SPEED_SHIFT);
   wire logic [15:0] step_torque = rated_torque >> torque_shift;
   wire logic target_reached = speed_fb >= inertia_target;
   wire logic attempt_timeout = acc_cnt == 32'(ATTEMPT_CYCLES - 1);
   wire logic final_attempt = torque_shift == TORQUE_SHIFT_LAST;
   wire logic rot_done = rot_cnt == 40'(ROT_CYCLES - 1);
   wire logic at_standstill = speed_fb == 16'h0000;
   wire logic [32:0] total_time = 33'(acc_cnt) + 33'(dec_cnt);
   wire logic [31:0] inertia_calc = 32'(total_time >> torque_shift);

   // ****************************************
   // Sequencer
   // ****************************************
   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (start_test && autotune_select == AT_CALC)
               next_state = ST_CALC;
            else if (start_test && autotune_select == AT_INERTIA)
               next_state = ST_ACC;
            else if (start_test)
               next_state = ST_STAT;
         end
         ST_STAT: begin
            if (stat_meas_done)
               next_state = ST_CALC;
         end
         ST_CALC: begin
            if (code == AT_ROT)
               next_state = ST_ROT;
            else
               next_state = ST_INHIBIT;
         end
         ST_ROT: begin
            if (rot_done)
               next_state = ST_INHIBIT;
         end
         ST_ACC: begin
            if (target_reached)
               next_state = ST_DEC;
            else if (attempt_timeout && final_attempt)
               next_state = ST_INHIBIT;
         end
         ST_DEC: begin
            if (at_standstill)
               next_state = ST_INHIBIT;
         end
         ST_INHIBIT: begin
            if (controlled_disable)
               next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state <= ST_IDLE;
         go_q <= 1'b0;
         code <= AT_NONE;
         test_reverse <= 1'b0;
      end else begin
         state <= next_state;
         go_q <= go;
         if (state == ST_IDLE && start_test) begin
            code <= autotune_select;
            test_reverse <= direction_reverse;
         end
      end
   end

   // Timers only run in their own state so each test starts from zero.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rot_cnt <= 40'h00_0000_0000;
         acc_cnt <= 32'h0000_0000;
         dec_cnt <= 32'h0000_0000;
         torque_shift <= TORQUE_SHIFT_FIRST;
      end else begin
         rot_cnt <= (state == ST_ROT) ? rot_cnt + 40'h00_0000_0001 : 40'h00_0000_0000;
         dec_cnt <= (state == ST_DEC) ? dec_cnt + 32'h0000_0001 : 32'h0000_0000;
         if (state == ST_IDLE) begin
            torque_shift <= TORQUE_SHIFT_FIRST;
            acc_cnt <= 32'h0000_0000;
         end else if (state == ST_ACC && attempt_timeout && !final_attempt) begin
            torque_shift <= torque_shift - 3'h1;
            acc_cnt <= 32'h0000_0000;
         end else if (state == ST_ACC && !target_reached) begin
            acc_cnt <= acc_cnt + 32'h0000_0001;
         end
      end
   end

   // ****************************************
   // Results and drive outputs
   // ****************************************
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         stator_resistance <= 16'h0000;
         transient_inductance <= 16'h0000;
         stator_inductance <= 16'h0000;
         saturation_breakpoint_one <= 16'h0000;
         saturation_breakpoint_two <= 16'h0000;
         current_loop_prop_gain <= 16'h0000;
         current_loop_int_gain <= 16'h0000;
         motor_load_inertia <= 32'h0000_0000;
         inertia_tune_fail_trip <= 1'b0;
      end else begin
         if (state == ST_STAT && stat_meas_done) begin
            stator_resistance <= stat_meas.resistance;
            transient_inductance <= stat_meas.inductance;
         end
         if (state == ST_CALC) begin
            current_loop_prop_gain <= current_gain_calc.kp;
            current_loop_int_gain <= current_gain_calc.ki;
         end
         if (state == ST_ROT && rot_done) begin
            stator_inductance <= rot_meas.inductance;
            saturation_breakpoint_one <= rot_meas.bp_one;
            saturation_breakpoint_two <= rot_meas.bp_two;
         end
         if (state == ST_DEC && at_standstill)
            motor_load_inertia <= inertia_calc;
         if (state == ST_ACC && attempt_timeout && final_attempt && !target_reached)
            inertia_tune_fail_trip <= 1'b1;
         else if (state == ST_IDLE && start_test)
            inertia_tune_fail_trip <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         freq_ref <= 16'h0000;
         torque_limit <= 16'h0000;
      end else begin
         freq_ref <= (next_state == ST_ROT) ? rot_freq : 16'h0000;
         torque_limit <= (next_state == ST_ACC || next_state == ST_DEC) ? step_torque :
            16'h0000;
      end
   end

   assign inhibit = state == ST_INHIBIT;
   assign test_busy = !(state == ST_IDLE || state == ST_INHIBIT);
   assign stationary_active = state == ST_STAT;
   assign run_permit = state == ST_IDLE && go && drive_enable_param &&
      !control_word_disable && !is_test_code(autotune_select);

   // ****************************************
   // Speed gain selection and controller
   // ****************************************
   wire speed_gains_t user_set = (speed_gain_set_select == GAINSET_ONE) ?
      user_gain_set_one : user_gain_set_two;
   wire loop_gains_t calc_set = (speed_gain_tuning_method == TUNE_COMPLIANCE) ?
      compliance_gain_calc : bandwidth_gain_calc;
   assign active_speed_gains = (speed_gain_tuning_method == TUNE_USER) ? user_set :
      '{kp: calc_set.kp, ki: calc_set.ki, kd: user_set.kd};

   speed_pid u_pid (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .enable(run_permit),
      .gains(active_speed_gains),
      .speed_ref(speed_ref),
      .speed_fb($signed({1'b0, speed_fb})),
      .torque_demand(torque_demand)
   );

   // The optimizer steps on a slow tick so its gain is independent of sys_clk.
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         tick_cnt <= 32'h0000_0000;
         opt_tick <= 1'b0;
      end else begin
         opt_tick <= tick_cnt == 32'(OPT_TICK_CYCLES - 1);
         tick_cnt <= (tick_cnt == 32'(OPT_TICK_CYCLES - 1)) ? 32'h0000_0000 :
            tick_cnt + 32'h0000_0001;
      end
   end

   slip_optimizer u_opt (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .opt_tick(opt_tick),
      .mode(rated_speed_optimizer_mode),
      .feedback_present(feedback_present),
      .speed(speed_fb),
      .load(load_fb),
      .rated_load(rated_load),
      .saved_speed(rated_speed_saved),
      .slip_error(slip_error),
      .motor_rated_speed(motor_rated_speed),
      .opt_active(optimizer_active)
   );

   // ****************************************
   // Checks
   // ****************************************
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   sequence calc_then_inhibit;
      state == ST_CALC ##1 state == ST_INHIBIT;
   endsequence
   a_bad_code_idle: assert property (state == ST_IDLE && go_rise &&
      !is_test_code(autotune_select) |=> state == ST_IDLE)
      else $error("test started for an unused selector code");
   a_no_restart: assert property (state == ST_IDLE && go && go_q |=> state == ST_IDLE)
      else $error("test started without a fresh enable and run");
   a_stat_gains: assert property (state == ST_STAT && stat_meas_done && code == AT_STAT
      |=> calc_then_inhibit)
      else $error("stationary test did not go through gain capture");
   a_calc_only: assert property (state == ST_IDLE && start_test && autotune_select == AT_CALC
      |=> calc_then_inhibit ##0 current_loop_prop_gain == $past(current_gain_calc.kp))
      else $error("gain calculation sequence wrong");
   a_rot_freq: assert property (state == ST_ROT && $past(state == ST_ROT)
      |-> freq_ref == $past(rot_freq))
      else $error("rotating test frequency wrong");
   a_first_torque: assert property (state == ST_IDLE && start_test &&
      autotune_select == AT_INERTIA |=> torque_shift == TORQUE_SHIFT_FIRST)
      else $error("inertia test not started at first torque step");
   a_fail_trip: assert property (state == ST_ACC && attempt_timeout && final_attempt &&
      !target_reached |=> inertia_tune_fail_trip && state == ST_INHIBIT)
      else $error("inertia failure did not trip");
   a_inertia_write: assert property (state == ST_DEC && at_standstill
      |=> motor_load_inertia == $past(inertia_calc))
      else $error("inertia result not written");
   a_inhibit_hold: assert property (inhibit && !controlled_disable
      |=> inhibit && !run_permit)
      else $error("inhibit left without controlled disable");
   a_gain_select: assert property (speed_gain_tuning_method == TUNE_USER &&
      speed_gain_set_select != GAINSET_ONE |-> active_speed_gains == user_gain_set_two)
      else $error("wrong speed gain set in use");
endmodule
`default_nettype wire

// *** motor_model.sv ***
// Far-side motor and measurement engine for the autotune sequencer bench.
// Assumes the sequencer drives stationary_active and torque_limit on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module motor_model (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic stationary_active,
   input wire logic [2:0] lag,
   input wire logic [15:0] torque_limit,
   input wire logic [15:0] coast_speed,
   output logic stat_meas_done,
   output logic [15:0] speed_fb
);
   logic [2:0] cnt;
   // A weak shaft: torque alone stays far below the inertia target, so every retry fails.
   // The bench adds coast_speed to stand for a free-running or strongly driven shaft.
   assign speed_fb = coast_speed + {8'h00, torque_limit[15:8]};
   // The measurement finishes a variable number of cycles after it starts.
   assign stat_meas_done = stationary_active && (cnt == lag);
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cnt <= 3'h0;
      end else begin
         cnt <= stationary_active ? cnt + 3'h1 : 3'h0;
      end
   end
endmodule
`default_nettype wire

// *** motor_autotune_sequencer_tb.sv ***
// Self-checking bench for the autotune sequencer with a weak motor model.
// Assumes shortened test durations; inputs change on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module motor_autotune_sequencer_tb;
   import autotune_pkg::*;
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
   $display("ERROR %0t mismatch %h %h", $time, a, b); end end
   logic sys_clk = 1'b0, resetn = 1'b0, enable_pin = 1'b0, run_pin = 1'b0;
   logic drive_enable_param = 1'b1, control_word_disable = 1'b0, direction_reverse = 1'b0;
   logic feedback_present = 1'b0, speed_gain_set_select = 1'b0, stat_meas_done;
   logic [2:0] autotune_select = 3'h0, lag = 3'h2;
   logic [15:0] motor_rated_frequency = 16'h0300, rated_speed_saved = 16'h1000;
   logic [15:0] rated_torque = 16'h0100, rated_load = 16'h0100, load_fb = 16'hffff, speed_fb;
   logic signed [15:0] slip_error = 16'sh0100;
   stat_meas_t stat_meas = '0;
   rot_meas_t rot_meas = '0;
   loop_gains_t current_gain_calc = '0, bandwidth_gain_calc = '0, compliance_gain_calc = '0;
   logic [1:0] rated_speed_optimizer_mode = 2'h2, speed_gain_tuning_method = 2'h0;
   speed_gains_t user_gain_set_one = '0, user_gain_set_two = '0, active_speed_gains;
   logic signed [16:0] speed_ref = 17'sh0_0040;
   logic run_permit, inhibit, test_busy, stationary_active, test_reverse;
   logic inertia_tune_fail_trip, optimizer_active;
   logic [15:0] freq_ref, torque_limit, stator_resistance, transient_inductance, stator_inductance;
   logic [15:0] saturation_breakpoint_one, saturation_breakpoint_two, current_loop_prop_gain;
   logic [15:0] current_loop_int_gain, motor_rated_speed, f, tq;
   logic [15:0] coast_speed = 16'h0000;
   logic [31:0] motor_load_inertia, seed = 32'h49b7_fe57;
   logic signed [31:0] torque_demand;
   int num_errors = 0, n_checks = 0, k;
   motor_autotune_sequencer #(.ROT_CYCLES(20), .ATTEMPT_CYCLES(10), .OPT_TICK_CYCLES(4))
      u_motor_autotune_sequencer (.*);
   motor_model u_motor_model (.*);
   always #2 sys_clk = ~sys_clk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic speed_gains_t exp_g(input logic [1:0] m, input logic s);
      speed_gains_t g;
      g = s ? user_gain_set_two : user_gain_set_one;
      if (m == TUNE_BANDWIDTH) g[47:16] = bandwidth_gain_calc;
      if (m == TUNE_COMPLIANCE) g[47:16] = compliance_gain_calc;
      return g;
   endfunction
   task automatic test_done;
      if (num_errors == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic run(input logic [2:0] code, input int i);
      @(negedge sys_clk);
      seed = lfsr(seed);
      stat_meas = seed;
      current_gain_calc = ~seed;
      rot_meas = {seed[15:0], seed};
      lag = seed[2:0];
      direction_reverse = seed[4];
      f = 16'h0000;
      tq = 16'h0000;
      autotune_select = code;
      enable_pin = 1'b1;
      run_pin = 1'b1;
      if (code == 3'h0 || code > 3'h4) begin
         repeat (10) @(negedge sys_clk);
         `CHK(test_busy, 1'b0)
         `CHK(run_permit, 1'b1)
      end else begin
         for (k = 0; k < 300 && inhibit !== 1'b1; k++) begin
            @(negedge sys_clk);
            if (test_busy && !stationary_active && freq_ref > f) f = freq_ref;
            if (tq === 16'h0000 && torque_limit !== 16'h0000) tq = torque_limit;
            if (k == 43) coast_speed = 16'h0000;
         end
         if (k == 300) begin
            num_errors++;
            test_done();
         end
         `CHK(run_permit, 1'b0)
         `CHK(torque_demand, 32'sh0000_0000)
         `CHK(test_reverse, direction_reverse)
         if (code == 3'h3) begin
            `CHK(tq, rated_torque >> 4)
            `CHK(inertia_tune_fail_trip, i != 4)
            // Forty cycles of coast-down at the first torque step, scaled by it, give two.
            if (i == 4) `CHK(motor_load_inertia, 32'h0000_0002)
         end else begin
            `CHK(current_loop_prop_gain, current_gain_calc.kp)
            `CHK(current_loop_int_gain, current_gain_calc.ki)
         end
         if (code <= 3'h2) `CHK(stator_resistance, stat_meas.resistance)
         if (code <= 3'h2) `CHK(transient_inductance, stat_meas.inductance)
         if (code == 3'h2) `CHK(saturation_breakpoint_one, rot_meas.bp_one)
         if (code == 3'h2) `CHK(saturation_breakpoint_two, rot_meas.bp_two)
         if (code == 3'h2) `CHK(stator_inductance, rot_meas.inductance)
         if (code == 3'h2) `CHK(f, motor_rated_frequency * 2 / 3)
         // Rotate through the three ways of a controlled disable.
         drive_enable_param = (i % 3 != 0);
         control_word_disable = (i % 3 == 1);
         if (i % 3 == 2) enable_pin = 1'b0;
         repeat (4) @(negedge sys_clk);
         drive_enable_param = 1'b1;
         control_word_disable = 1'b0;
         repeat (6) @(negedge sys_clk);
         `CHK(inhibit, 1'b0)
         `CHK(test_busy, 1'b0)
      end
      enable_pin = 1'b0;
      run_pin = 1'b0;
      repeat (3) @(negedge sys_clk);
   endtask
   initial begin
      repeat (10) @(posedge sys_clk);
      @(negedge sys_clk);
      resetn = 1'b1;
      repeat (3) @(negedge sys_clk);
      `CHK(motor_rated_speed, rated_speed_saved)
      for (int j = 0; j < 12; j++) begin
         seed = lfsr(seed);
         user_gain_set_one = {seed, seed[15:0]};
         bandwidth_gain_calc = ~seed;
         seed = lfsr(seed);
         user_gain_set_two = {seed[15:0], seed};
         compliance_gain_calc = seed;
         speed_gain_set_select = seed[3];
         speed_gain_tuning_method = (seed[5:4] == 2'h3) ? 2'h0 : seed[5:4];
         #1;
         `CHK(active_speed_gains, exp_g(speed_gain_tuning_method, speed_gain_set_select))
         if (j == 6) run(3'h4, 0);
         @(negedge sys_clk);
      end
      run(3'h1, 1);
      run(3'h2, 2);
      run(3'h3, 3);
      // A strong shaft reaches the target at once and is told to stop later.
      coast_speed = 16'hffff;
      run(3'h3, 4);
      run(3'h0, 0);
      run(3'h5, 0);
      run(3'h2, 0);
      `CHK(optimizer_active, 1'b0)
      `CHK(motor_rated_speed, rated_speed_saved)
      // Heavy load on a spinning shaft with feedback lets the optimizer step.
      coast_speed = 16'h0400;
      feedback_present = 1'b1;
      f = motor_rated_speed;
      for (k = 0; k < 8 && motor_rated_speed === f; k++) @(negedge sys_clk);
      `CHK(optimizer_active, 1'b1)
      `CHK(motor_rated_speed, f + slip_error)
      rated_speed_optimizer_mode = 2'h1;
      f = motor_rated_speed;
      for (k = 0; k < 8 && motor_rated_speed === f; k++) @(negedge sys_clk);
      `CHK(motor_rated_speed, f + (slip_error >>> 4))
      load_fb = 16'h0090;
      @(negedge sys_clk);
      `CHK(optimizer_active, 1'b1)
      load_fb = 16'h0070;
      repeat (2) @(negedge sys_clk);
      `CHK(optimizer_active, 1'b0)
      // A reset in mid-run drops the adjusted rated speed.
      resetn = 1'b0;
      @(negedge sys_clk);
      resetn = 1'b1;
      repeat (3) @(negedge sys_clk);
      `CHK(motor_rated_speed, rated_speed_saved)
      test_done();
   end
endmodule
`default_nettype wire
